/* core/msd_pkg.sv */
package msd_pkg;

  // Command byte codes
  localparam logic [7:0] CMD_FULL_STATUS = 8'h81;
  localparam logic [7:0] CMD_POS_REPORT  = 8'hFC;
  localparam logic [7:0] CMD_OTP_DUMP    = 8'h82;
  localparam logic [7:0] CMD_GOTO_SAFE   = 8'h84;
  localparam logic [7:0] CMD_HALT        = 8'h85;
  localparam logic [7:0] CMD_ZERO_POS    = 8'h86;

  // Slave address layout
  localparam logic [1:0] ADDR_TOP_BITS   = 2'h3;
  localparam logic [6:0] BCAST_ADDR      = 7'h00;
  localparam int         ADDR_RW_BIT     = 0;

  // Position fields
  localparam logic [10:0] SAFE_DISABLED  = 11'h400;
  localparam logic [1:0]  STEP_HALF      = 2'h0;
  localparam int          HALF_MASK_BITS = 3;
  localparam logic [4:0]  FILL_HI_ONES   = 5'h1F;
  localparam logic [7:0]  FILL_BYTE      = 8'hFF;
  localparam logic [2:0]  ADDR_ECHO_PAD  = 3'h0;

  // Response framing
  localparam int          RESP_BYTES     = 9;
  localparam logic [3:0]  RESP_COUNT     = 4'h9;

endpackage

/* core/msd_link_port.sv */
`timescale 1ns/1ps
module msd_link_port (
  // Link clock side
  input  wire logic        clk_link,
  input  wire logic        rst_req,
  input  wire logic        rx_valid,
  input  wire logic        rx_first,
  input  wire logic [7:0]  rx_data,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  // Core side
  input  wire logic [71:0] resp_bytes,
  input  wire logic        resp_tgl,
  output logic             cmd_tgl,
  output logic [7:0]       req_addr,
  output logic [7:0]       req_cmd
);

  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        rt_s1;
    logic        rt_s2;
    logic        rt_prev;
    logic        have_addr;
    logic [7:0]  addr_tmp;
    logic [7:0]  addr;
    logic [7:0]  cmd;
    logic        tgl;
    logic [71:0] sh;
    logic [3:0]  left;
    logic        tx_valid;
  } msd_link_s;

  msd_link_s s_ff;
  msd_link_s nxt_s;

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.rst_s1 = rst_req;
    nxt_s.rst_s2 = s_ff.rst_s1;
    nxt_s.rt_s1  = resp_tgl;
    nxt_s.rt_s2  = s_ff.rt_s1;
    nxt_s.rt_prev = s_ff.rt_s2;
    if (s_ff.rst_s2) begin
      nxt_s.have_addr = 1'b0;
      nxt_s.addr_tmp  = 8'h00;
      nxt_s.addr      = 8'h00;
      nxt_s.cmd       = 8'h00;
      nxt_s.tgl       = 1'b0;
      nxt_s.sh        = 72'h0;
      nxt_s.left      = 4'h0;
      nxt_s.tx_valid  = 1'b0;
    end else begin
      // Frame capture: first byte is the address, next the command
      if (rx_valid && rx_first) begin
        nxt_s.addr_tmp  = rx_data;
        nxt_s.have_addr = 1'b1;
      end else if (rx_valid && s_ff.have_addr) begin
        nxt_s.addr      = s_ff.addr_tmp;
        nxt_s.cmd       = rx_data;
        nxt_s.have_addr = 1'b0;
        nxt_s.tgl       = ~s_ff.tgl;
      end
      // Response byte stream, byte 0 first
      if (s_ff.rt_s2 ^ s_ff.rt_prev) begin
        nxt_s.sh       = resp_bytes;
        nxt_s.left     = msd_pkg::RESP_COUNT;
        nxt_s.tx_valid = 1'b1;
      end else if (s_ff.tx_valid && tx_ready) begin
        nxt_s.sh       = {8'h00, s_ff.sh[71:8]};
        nxt_s.left     = s_ff.left - 4'h1;
        nxt_s.tx_valid = (s_ff.left != 4'h1);
      end
    end
  end

  always_ff @(posedge clk_link) begin
    s_ff <= nxt_s;
  end

  assign tx_valid = s_ff.tx_valid;
  assign tx_data  = s_ff.sh[7:0];
  assign cmd_tgl  = s_ff.tgl;
  assign req_addr = s_ff.addr;
  assign req_cmd  = s_ff.cmd;

endmodule

/* core/msd_cmd_decoder.sv */
`timescale 1ns/1ps
module msd_cmd_decoder #(
  parameter int POS_W  = 16,
  parameter int SAFE_W = 11,
  parameter int OTP_N  = 8
) (
  // Device clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 RST,
  // Node address
  input  wire logic [3:0]           NODE_ADDR_BITS,
  input  wire logic                 HW_ADDRESS_PIN_BIT,
  // Memory contents, byte 0 in the low bits
  input  wire logic [OTP_N*8-1:0]   OTP_BYTES,
  // Motion state
  input  wire logic [POS_W-1:0]     ACTUAL_POSITION,
  input  wire logic [POS_W-1:0]     TARGET_POSITION,
  input  wire logic [SAFE_W-1:0]    SAFE_POSITION,
  input  wire logic [1:0]           STEP_RESOLUTION,
  input  wire logic                 MOTOR_MOVING,
  input  wire logic                 REFERENCE_SEARCH_DONE,
  input  wire logic                 DEADLOCK_ENTER,
  // Coil fault detectors
  input  wire logic                 COIL_A_FAULT,
  input  wire logic                 COIL_B_FAULT,
  // Motor controls
  output logic                      HALT,
  output logic                      BRIDGE_OFF,
  output logic                      GOTO_SAFE,
  output logic [SAFE_W-1:0]         GOTO_SAFE_TARGET,
  output logic                      ZERO_POSITION,
  output logic                      LOST_STEPS_FLAG,
  output logic                      DEADLOCK,
  // Link byte port
  input  wire logic                 LINK_CLK,
  input  wire logic                 LINK_RX_VALID,
  input  wire logic                 LINK_RX_FIRST,
  input  wire logic [7:0]           LINK_RX_DATA,
  input  wire logic                 LINK_TX_READY,
  output logic                      LINK_TX_VALID,
  output logic [7:0]                LINK_TX_DATA
);

  typedef struct packed {
    logic                hw_s1;
    logic                hw_s2;
    logic                ct_s1;
    logic                ct_s2;
    logic                ct_prev;
    logic                fault_prev;
    logic [8:0][7:0]     resp;
    logic                resp_tgl;
    logic                halt;
    logic                bridge_off;
    logic                goto_safe;
    logic [SAFE_W-1:0]   safe_target;
    logic                zero_pos;
    logic                lost_steps;
    logic                deadlock;
    logic                halt_seen;
  } msd_core_s;

  msd_core_s s_ff;
  msd_core_s nxt_s;

  logic       cmd_tgl;
  logic [7:0] req_addr;
  logic [7:0] req_cmd;
  logic       cmd_evt;
  logic [6:0] node_addr;
  logic       addr_hit;
  logic       addr_bcast;
  logic       write_req;
  logic       coil_fault;
  logic       fault_rise;
  logic       do_report;
  logic       do_dump;
  logic       do_goto;
  logic       do_halt;
  logic       do_zero;
  logic       do_full;
  logic       safe_enabled;

  logic [POS_W-1:0] act_view;

  function automatic logic [POS_W-1:0] pos_view(input logic [POS_W-1:0] pos,
                                                input logic [1:0]       res);
    logic [POS_W-1:0] v;
    v = pos;
    if (res == msd_pkg::STEP_HALF) begin
      v[msd_pkg::HALF_MASK_BITS-1:0] = '0;
    end
    return v;
  endfunction

  function automatic logic cmd_is(input logic [7:0] cmd, input logic [7:0] code);
    return cmd == code;
  endfunction

  msd_link_port u_link (
    .clk_link   (LINK_CLK),
    .rst_req    (RST),
    .rx_valid   (LINK_RX_VALID),
    .rx_first   (LINK_RX_FIRST),
    .rx_data    (LINK_RX_DATA),
    .tx_ready   (LINK_TX_READY),
    .tx_valid   (LINK_TX_VALID),
    .tx_data    (LINK_TX_DATA),
    .resp_bytes (s_ff.resp),
    .resp_tgl   (s_ff.resp_tgl),
    .cmd_tgl    (cmd_tgl),
    .req_addr   (req_addr),
    .req_cmd    (req_cmd)
  );

  // Command decode; address and command hold still while the toggle crosses
  assign cmd_evt      = s_ff.ct_s2 ^ s_ff.ct_prev;
  assign node_addr    = {msd_pkg::ADDR_TOP_BITS, NODE_ADDR_BITS, s_ff.hw_s2};
  assign addr_hit     = (req_addr[7:1] == node_addr);
  assign addr_bcast   = (req_addr[7:1] == msd_pkg::BCAST_ADDR);
  assign write_req    = !req_addr[msd_pkg::ADDR_RW_BIT];
  assign coil_fault   = COIL_A_FAULT || COIL_B_FAULT;
  assign fault_rise   = coil_fault && !s_ff.fault_prev;
  assign safe_enabled = (SAFE_POSITION != msd_pkg::SAFE_DISABLED);
  assign act_view     = pos_view(ACTUAL_POSITION, STEP_RESOLUTION);
  assign do_report = cmd_evt && addr_hit && write_req
                     && cmd_is(req_cmd, msd_pkg::CMD_POS_REPORT);
  assign do_dump   = cmd_evt && addr_hit && write_req
                     && cmd_is(req_cmd, msd_pkg::CMD_OTP_DUMP);
  assign do_goto   = cmd_evt && (addr_hit || addr_bcast) && write_req
                     && cmd_is(req_cmd, msd_pkg::CMD_GOTO_SAFE);
  assign do_halt   = cmd_evt && addr_hit && write_req
                     && cmd_is(req_cmd, msd_pkg::CMD_HALT);
  assign do_zero   = cmd_evt && addr_hit && write_req
                     && cmd_is(req_cmd, msd_pkg::CMD_ZERO_POS);
  assign do_full   = cmd_evt && addr_hit && write_req
                     && cmd_is(req_cmd, msd_pkg::CMD_FULL_STATUS);

  always_comb begin
    nxt_s          = s_ff;
    nxt_s.hw_s1    = HW_ADDRESS_PIN_BIT;
    nxt_s.hw_s2    = s_ff.hw_s1;
    nxt_s.ct_s1    = cmd_tgl;
    nxt_s.ct_s2    = s_ff.ct_s1;
    nxt_s.ct_prev  = s_ff.ct_s2;
    nxt_s.fault_prev = coil_fault;
    nxt_s.halt     = 1'b0;
    nxt_s.goto_safe = 1'b0;
    nxt_s.zero_pos = 1'b0;
    if (RST) begin
      nxt_s = '0;
    end else begin
      // Position report frame
      if (do_report) begin
        nxt_s.resp[0] = {node_addr, 1'b1};
        nxt_s.resp[1] = {msd_pkg::ADDR_ECHO_PAD, NODE_ADDR_BITS, s_ff.hw_s2};
        nxt_s.resp[2] = act_view[15:8];
        nxt_s.resp[3] = act_view[7:0];
        nxt_s.resp[4] = TARGET_POSITION[15:8];
        nxt_s.resp[5] = TARGET_POSITION[7:0];
        nxt_s.resp[6] = SAFE_POSITION[7:0];
        nxt_s.resp[7] = {msd_pkg::FILL_HI_ONES, SAFE_POSITION[10:8]};
        nxt_s.resp[8] = msd_pkg::FILL_BYTE;
        nxt_s.resp_tgl = ~s_ff.resp_tgl;
      end
      // Memory dump frame
      if (do_dump) begin
        nxt_s.resp[0] = {node_addr, 1'b1};
        for (int i = 0; i < OTP_N; i++) begin
          nxt_s.resp[i+1] = OTP_BYTES[i*8 +: 8];
        end
        nxt_s.resp_tgl = ~s_ff.resp_tgl;
      end
      // Safe move, by command or at end of reference search
      if ((do_goto || REFERENCE_SEARCH_DONE) && safe_enabled) begin
        nxt_s.goto_safe   = 1'b1;
        nxt_s.safe_target = SAFE_POSITION;
      end
      // Hard stop from command or coil fault
      nxt_s.halt       = do_halt || fault_rise;
      nxt_s.bridge_off = coil_fault;
      // Position zeroing only at rest
      nxt_s.zero_pos = do_zero && !MOTOR_MOVING;
      // Lost steps: set wins over the status-read clear
      if (do_full) begin
        nxt_s.lost_steps = 1'b0;
      end
      if (fault_rise && MOTOR_MOVING) begin
        nxt_s.lost_steps = 1'b1;
      end
      // Deadlock exit needs halt then full status read
      if (s_ff.deadlock && do_halt) begin
        nxt_s.halt_seen = 1'b1;
      end
      if (do_full && s_ff.halt_seen) begin
        nxt_s.deadlock  = 1'b0;
        nxt_s.halt_seen = 1'b0;
      end
      if (DEADLOCK_ENTER) begin
        nxt_s.deadlock  = 1'b1;
        nxt_s.halt_seen = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    s_ff <= nxt_s;
  end

  assign HALT             = s_ff.halt;
  assign BRIDGE_OFF       = s_ff.bridge_off;
  assign GOTO_SAFE        = s_ff.goto_safe;
  assign GOTO_SAFE_TARGET = s_ff.safe_target;
  assign ZERO_POSITION    = s_ff.zero_pos;
  assign LOST_STEPS_FLAG  = s_ff.lost_steps;
  assign DEADLOCK         = s_ff.deadlock;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_fault_halt;
    fault_rise |=> HALT && BRIDGE_OFF;
  endproperty
  a_fault_halt: assert property (p_fault_halt) else $error("fault did not halt");

  property p_lost_steps;
    fault_rise && MOTOR_MOVING |=> LOST_STEPS_FLAG;
  endproperty
  a_lost_steps: assert property (p_lost_steps) else $error("lost steps not set");

  property p_cmd_halt;
    do_halt |=> HALT ##1 !HALT || $past(fault_rise);
  endproperty
  a_cmd_halt: assert property (p_cmd_halt) else $error("halt command missed");

  property p_safe_disabled;
    GOTO_SAFE |-> GOTO_SAFE_TARGET != msd_pkg::SAFE_DISABLED;
  endproperty
  a_safe_disabled: assert property (p_safe_disabled) else $error("disabled safe move");

  property p_goto;
    do_goto && safe_enabled |=> GOTO_SAFE && GOTO_SAFE_TARGET == $past(SAFE_POSITION);
  endproperty
  a_goto: assert property (p_goto) else $error("safe move missed");

  property p_zero_rest;
    ZERO_POSITION |-> !$past(MOTOR_MOVING) && $past(do_zero);
  endproperty
  a_zero_rest: assert property (p_zero_rest) else $error("zero while moving");

  property p_half_mask;
    do_report && STEP_RESOLUTION == msd_pkg::STEP_HALF |=> s_ff.resp[3][2:0] == 3'h0;
  endproperty
  a_half_mask: assert property (p_half_mask) else $error("low bits not masked");

  property p_report_tail;
    do_report |=> s_ff.resp[7][7:3] == msd_pkg::FILL_HI_ONES
                  && s_ff.resp[8] == msd_pkg::FILL_BYTE
                  && s_ff.resp[1][7:5] == msd_pkg::ADDR_ECHO_PAD;
  endproperty
  a_report_tail: assert property (p_report_tail) else $error("report fill wrong");

  property p_dump;
    do_dump |=> s_ff.resp[1] == $past(OTP_BYTES[7:0]) && s_ff.resp[0][0];
  endproperty
  a_dump: assert property (p_dump) else $error("dump frame wrong");

  property p_unknown;
    cmd_evt && !(do_report || do_dump || do_goto || do_halt || do_zero)
      && !REFERENCE_SEARCH_DONE |=> $stable(s_ff.resp) && !GOTO_SAFE && !ZERO_POSITION;
  endproperty
  a_unknown: assert property (p_unknown) else $error("ignored frame acted");

  property p_deadlock_exit;
    $fell(DEADLOCK) |-> $past(do_full) && $past(s_ff.halt_seen);
  endproperty
  a_deadlock_exit: assert property (p_deadlock_exit) else $error("bad deadlock exit");

  property p_zero_cmd;
    do_zero && !MOTOR_MOVING |=> ZERO_POSITION;
  endproperty
  a_zero_cmd: assert property (p_zero_cmd) else $error("zero command missed");

  property p_report_pos;
    do_report |=> s_ff.resp[2] == $past(ACTUAL_POSITION[15:8])
                  && s_ff.resp[4] == $past(TARGET_POSITION[15:8])
                  && s_ff.resp[5] == $past(TARGET_POSITION[7:0]);
  endproperty
  a_report_pos: assert property (p_report_pos) else $error("report position wrong");

  property p_report_safe;
    do_report |=> s_ff.resp[6] == $past(SAFE_POSITION[7:0])
                  && s_ff.resp[7][2:0] == $past(SAFE_POSITION[10:8]);
  endproperty
  a_report_safe: assert property (p_report_safe) else $error("report safe wrong");

  property p_addr_echo;
    do_report |=> s_ff.resp[1][4:0] == $past({NODE_ADDR_BITS, s_ff.hw_s2});
  endproperty
  a_addr_echo: assert property (p_addr_echo) else $error("address echo wrong");

  property p_dump_last;
    do_dump |=> s_ff.resp[8] == $past(OTP_BYTES[OTP_N*8-1 -: 8])
                && s_ff.resp[0] == {$past(node_addr), 1'b1};
  endproperty
  a_dump_last: assert property (p_dump_last) else $error("dump tail wrong");

  property p_search_goto;
    REFERENCE_SEARCH_DONE && safe_enabled |=> GOTO_SAFE
                                            && GOTO_SAFE_TARGET == $past(SAFE_POSITION);
  endproperty
  a_search_goto: assert property (p_search_goto) else $error("search safe move missed");

  property p_bridge_follow;
    !$past(RST) |-> BRIDGE_OFF == $past(coil_fault);
  endproperty
  a_bridge_follow: assert property (p_bridge_follow) else $error("bridge state wrong");

  property p_foreign_addr;
    cmd_evt && !addr_hit && !addr_bcast
      |=> $stable(s_ff.resp) && !ZERO_POSITION && (!HALT || $past(fault_rise));
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign frame acted");

  property p_lost_sticky;
    $fell(LOST_STEPS_FLAG) |-> $past(do_full);
  endproperty
  a_lost_sticky: assert property (p_lost_sticky) else $error("lost steps dropped");

  c_report: cover property (do_report ##1 s_ff.resp_tgl != $past(s_ff.resp_tgl));
  c_dump:   cover property (do_dump);
  c_goto:   cover property (GOTO_SAFE);
  c_zero:   cover property (ZERO_POSITION);
  c_halt:   cover property (do_halt ##1 HALT);

endmodule

/* bench/msd_link_master.sv */
`timescale 1ns/1ps
// Host side of the link: sends address and command bytes, takes response bytes
module msd_link_master (
  // Link clock
  input  wire logic       link_clk,
  // Request bytes towards the device
  output logic            rx_valid,
  output logic            rx_first,
  output logic [7:0]      rx_data,
  // Response bytes from the device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Address byte first, then command byte; data line left at the inverted command when idle
  task automatic send(input logic [7:0] a, input logic [7:0] c);
    @(posedge link_clk);
    rx_valid <= 1'b1;
    rx_first <= 1'b1;
    rx_data  <= a;
    @(posedge link_clk);
    rx_first <= 1'b0;
    rx_data  <= c;
    @(posedge link_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~c;
  endtask

  // Takes nine bytes with random stalls; to is set when they do not come
  task automatic take(output logic [71:0] r, output logic to);
    int n;
    n = 0;
    r = '0;
    for (int k = 0; k < 600 && n < 9; k++) begin
      @(posedge link_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r[8*n+:8] = tx_data;
        n++;
      end
      tx_ready <= (n < 9) && (($urandom % 3) != 0);
    end
    to = (n != 9);
  endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        REF_CLK = 1'b0, RST = 1'b1, LINK_CLK = 1'b0;
  logic [3:0]  NODE_ADDR_BITS;
  logic        HW_ADDRESS_PIN_BIT, MOTOR_MOVING, REFERENCE_SEARCH_DONE, DEADLOCK_ENTER;
  logic [63:0] OTP_BYTES;
  logic [15:0] ACTUAL_POSITION, TARGET_POSITION;
  logic [10:0] SAFE_POSITION, GOTO_SAFE_TARGET;
  logic [1:0]  STEP_RESOLUTION;
  logic        COIL_A_FAULT, COIL_B_FAULT, HALT, BRIDGE_OFF, GOTO_SAFE, ZERO_POSITION;
  logic        LOST_STEPS_FLAG, DEADLOCK, RX_VALID, RX_FIRST, TX_READY, TX_VALID, to;
  logic [7:0]  RX_DATA, TX_DATA, sa;
  logic [71:0] r;
  int          mismatches = 0, checked = 0, n_halt = 0, n_goto = 0, n_zero = 0;

  always #50 REF_CLK = ~REF_CLK;
  initial #7 forever #15 LINK_CLK = ~LINK_CLK;
  always @(posedge REF_CLK) begin
    n_halt <= n_halt + int'(HALT === 1'b1);
    n_goto <= n_goto + int'(GOTO_SAFE === 1'b1);
    n_zero <= n_zero + int'(ZERO_POSITION === 1'b1);
  end

  msd_cmd_decoder u_dut (.REF_CLK(REF_CLK), .RST(RST), .NODE_ADDR_BITS(NODE_ADDR_BITS),
    .HW_ADDRESS_PIN_BIT(HW_ADDRESS_PIN_BIT), .OTP_BYTES(OTP_BYTES),
    .ACTUAL_POSITION(ACTUAL_POSITION), .TARGET_POSITION(TARGET_POSITION),
    .SAFE_POSITION(SAFE_POSITION), .STEP_RESOLUTION(STEP_RESOLUTION),
    .MOTOR_MOVING(MOTOR_MOVING), .REFERENCE_SEARCH_DONE(REFERENCE_SEARCH_DONE),
    .DEADLOCK_ENTER(DEADLOCK_ENTER), .COIL_A_FAULT(COIL_A_FAULT), .COIL_B_FAULT(COIL_B_FAULT),
    .HALT(HALT), .BRIDGE_OFF(BRIDGE_OFF), .GOTO_SAFE(GOTO_SAFE),
    .GOTO_SAFE_TARGET(GOTO_SAFE_TARGET), .ZERO_POSITION(ZERO_POSITION),
    .LOST_STEPS_FLAG(LOST_STEPS_FLAG), .DEADLOCK(DEADLOCK), .LINK_CLK(LINK_CLK),
    .LINK_RX_VALID(RX_VALID), .LINK_RX_FIRST(RX_FIRST), .LINK_RX_DATA(RX_DATA),
    .LINK_TX_READY(TX_READY), .LINK_TX_VALID(TX_VALID), .LINK_TX_DATA(TX_DATA));

  msd_link_master u_link (.link_clk(LINK_CLK), .rx_valid(RX_VALID), .rx_first(RX_FIRST),
    .rx_data(RX_DATA), .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY));

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
    checked++;
    if (g !== ex) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, ex, g);
    end
  endtask

  // Reads a response and compares all nine bytes
  task automatic cmp_resp(input logic [71:0] ex);
    u_link.take(r, to);
    chk("response timeout", 16'h0, {15'h0, to});
    if (to) finish_test();
    for (int j = 0; j < 9; j++) chk("response byte", ex[8*j+:8], r[8*j+:8]);
  endtask

  // Sends a frame and compares pulse counts of halt, goto and zero
  task automatic act(input logic [7:0] a, input logic [7:0] c, input logic [2:0] x);
    int h, g, z;
    h = n_halt;
    g = n_goto;
    z = n_zero;
    u_link.send(a, c);
    repeat (30) @(posedge REF_CLK);
    chk("halt pulses", {15'h0, x[2]}, 16'(n_halt - h));
    chk("goto pulses", {15'h0, x[1]}, 16'(n_goto - g));
    chk("zero pulses", {15'h0, x[0]}, 16'(n_zero - z));
  endtask

  task automatic strobe(input bit dl);
    @(posedge REF_CLK);
    if (dl) DEADLOCK_ENTER <= 1'b1;
    else REFERENCE_SEARCH_DONE <= 1'b1;
    @(posedge REF_CLK);
    DEADLOCK_ENTER <= 1'b0;
    REFERENCE_SEARCH_DONE <= 1'b0;
    repeat (5) @(posedge REF_CLK);
  endtask

  function automatic logic [71:0] rep_exp(input logic [1:0] sr);
    logic [15:0] q;
    q = ACTUAL_POSITION;
    if (sr == 2'h0) q[2:0] = 3'h0;
    return {8'hFF, 5'h1F, SAFE_POSITION[10:8], SAFE_POSITION[7:0], TARGET_POSITION[7:0],
            TARGET_POSITION[15:8], q[7:0], q[15:8], 3'h0, NODE_ADDR_BITS, HW_ADDRESS_PIN_BIT,
            sa | 8'h01};
  endfunction

  initial begin
    void'($urandom(52909));
    NODE_ADDR_BITS = 4'($urandom);
    HW_ADDRESS_PIN_BIT = 1'($urandom);
    {MOTOR_MOVING, REFERENCE_SEARCH_DONE, DEADLOCK_ENTER, COIL_A_FAULT, COIL_B_FAULT} = '0;
    OTP_BYTES = {$urandom, $urandom};
    {ACTUAL_POSITION, TARGET_POSITION} = $urandom;
    SAFE_POSITION = 11'h123;
    STEP_RESOLUTION = 2'h0;
    sa = {2'h3, NODE_ADDR_BITS, HW_ADDRESS_PIN_BIT, 1'b0};
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    for (int i = 0; i < 8; i++) begin
      {ACTUAL_POSITION, TARGET_POSITION} <= (i == 0) ? 32'hFFFF_FFFF : $urandom;
      SAFE_POSITION <= (i == 1) ? 11'h7FF : (11'($urandom) | 11'h001);
      STEP_RESOLUTION <= 2'(i);
      repeat (2) @(posedge REF_CLK);
      u_link.send(sa, 8'hFC);
      cmp_resp(rep_exp(STEP_RESOLUTION));
    end
    u_link.send(sa, 8'h82);
    cmp_resp({OTP_BYTES, sa | 8'h01});
    act(sa, 8'h84, 3'b010);
    chk("goto target", {5'h0, SAFE_POSITION}, {5'h0, GOTO_SAFE_TARGET});
    act(8'h00, 8'h84, 3'b010);
    act(sa ^ 8'h04, 8'h84, 3'b000);
    act(sa | 8'h01, 8'h85, 3'b000);
    strobe(1'b0);
    chk("search goto", 16'h0003, 16'(n_goto));
    SAFE_POSITION <= 11'h400;
    act(sa, 8'h84, 3'b000);
    act(8'h00, 8'h84, 3'b000);
    strobe(1'b0);
    chk("disabled search goto", 16'h0003, 16'(n_goto));
    act(sa, 8'h85, 3'b100);
    act(sa, 8'h86, 3'b001);
    MOTOR_MOVING <= 1'b1;
    act(sa, 8'h86, 3'b000);
    for (int i = 0; i < 4; i++) act(sa, 8'h87 + 8'(i), 3'b000);
    COIL_A_FAULT <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    chk("bridge off", 16'h0001, {15'h0, BRIDGE_OFF});
    chk("lost steps", 16'h0001, {15'h0, LOST_STEPS_FLAG});
    chk("fault halt", 16'h0001, 16'(n_halt - 1));
    COIL_A_FAULT <= 1'b0;
    MOTOR_MOVING <= 1'b0;
    act(sa, 8'h81, 3'b000);
    chk("bridge on", 16'h0000, {15'h0, BRIDGE_OFF});
    chk("lost cleared", 16'h0000, {15'h0, LOST_STEPS_FLAG});
    COIL_B_FAULT <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    chk("bridge off b", 16'h0001, {15'h0, BRIDGE_OFF});
    chk("lost at rest", 16'h0000, {15'h0, LOST_STEPS_FLAG});
    COIL_B_FAULT <= 1'b0;
    strobe(1'b1);
    act(sa, 8'h81, 3'b000);
    chk("deadlock held", 16'h0001, {15'h0, DEADLOCK});
    act(sa, 8'h85, 3'b100);
    chk("deadlock after halt", 16'h0001, {15'h0, DEADLOCK});
    act(sa, 8'h81, 3'b000);
    chk("deadlock left", 16'h0000, {15'h0, DEADLOCK});
    finish_test();
  end
endmodule
